// ---- hw/msld_top.sv ----
/*
 * module status indicator driver: maps device condition inputs onto
 * a bi-colour red/green indicator, with a power-up test sequence.
 * assumes status inputs are synchronous to sys_clk and held as levels.
 */
// Function
// - operational status gives steady green, red off.
// - unconfigured standby gives flashing green.
// - recoverable fault, including bad configuration, gives flashing red.
// - unrecoverable fault gives steady red.
// - self-test shows green 0.25 s, red 0.25 s, then green until done.
// - module test runs before or with any network indicator test.
// - several network indicator tests may run in turn or together.
// - after the test completes, show the current normal pattern.
// - single bi-colour element; each pattern selects red, green or none.
`timescale 1ns/1ns
`default_nettype none
module msld_top #(
   parameter int unsigned TEST_CYC = msld_pkg::TEST_PHASE_CYC,
   parameter int unsigned FLASH_CYC = msld_pkg::FLASH_HALF_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // device condition
   input wire logic selftest_active,
   input wire logic stat_operational,
   input wire logic stat_standby,
   input wire logic fault_recoverable,
   input wire logic fault_unrecoverable,
   // network indicator test release
   output logic net_test_enable,
   // indicator drive
   output logic led_red,
   output logic led_green
);
   // ************************************************
   // timers
   // ************************************************
   msld_if test_if ();
   msld_if flash_if ();
   msld_timer #(.PERIOD(TEST_CYC)) u_test_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .tif(test_if.timer)
   );
   msld_timer #(.PERIOD(FLASH_CYC)) u_flash_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .tif(flash_if.timer)
   );
   // ************************************************
   // self-test sequence
   // ************************************************
   msld_pkg::msld_test_state_type st_reg;
   msld_pkg::msld_test_state_type st_next;
   logic test_prev_reg;
   logic test_start;
   assign test_start = selftest_active && !test_prev_reg;
   assign test_if.restart = test_start;
   always_comb begin
      st_next = st_reg;
      if (test_start) begin
         st_next = msld_pkg::MSLD_ST_GREEN1;
      end else begin
         case (st_reg)
            msld_pkg::MSLD_ST_GREEN1: begin
               if (test_if.expired) begin
                  st_next = msld_pkg::MSLD_ST_RED;
               end
            end
            msld_pkg::MSLD_ST_RED: begin
               if (test_if.expired) begin
                  st_next = msld_pkg::MSLD_ST_GREEN2;
               end
            end
            msld_pkg::MSLD_ST_GREEN2: begin
               if (!selftest_active) begin
                  st_next = msld_pkg::MSLD_ST_DONE;
               end
            end
            msld_pkg::MSLD_ST_DONE: begin
               st_next = msld_pkg::MSLD_ST_DONE;
            end
            default: begin
               st_next = msld_pkg::MSLD_ST_DONE;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= msld_pkg::MSLD_ST_DONE;
         test_prev_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         test_prev_reg <= selftest_active;
      end
   end
   // network tests start only once ours has begun (same cycle allowed)
   // each network indicator may then run in turn or together
   assign net_test_enable = selftest_active;
   // ************************************************
   // flashing phase
   // ************************************************
   logic phase_reg;
   assign flash_if.restart = 1'b0;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 1'b0;
      end else if (flash_if.expired) begin
         phase_reg <= !phase_reg;
      end
   end
   // ************************************************
   // pattern select
   // ************************************************
   msld_pkg::msld_pattern_type pat;
   wire logic in_test = selftest_active || (st_reg != msld_pkg::MSLD_ST_DONE);
   // status inputs are held levels from the host
   assign pat = msld_pkg::msld_pattern_type'(in_test ? msld_pkg::MSLD_TEST :
                fault_unrecoverable ? msld_pkg::MSLD_RED :
                fault_recoverable ? msld_pkg::MSLD_FLASH_RED :
                stat_standby ? msld_pkg::MSLD_FLASH_GREEN :
                stat_operational ? msld_pkg::MSLD_GREEN :
                msld_pkg::MSLD_OFF);
   logic red_next;
   logic green_next;
   wire logic test_red = (st_reg == msld_pkg::MSLD_ST_RED) && !test_start;
   always_comb begin
      red_next = 1'b0;
      green_next = 1'b0;
      case (pat)
         msld_pkg::MSLD_TEST: begin
            red_next = test_red;
            green_next = !test_red;
         end
         msld_pkg::MSLD_RED: red_next = 1'b1;
         msld_pkg::MSLD_FLASH_RED: red_next = phase_reg;
         msld_pkg::MSLD_FLASH_GREEN: green_next = phase_reg;
         msld_pkg::MSLD_GREEN: green_next = 1'b1;
         default: begin
            red_next = 1'b0;
            green_next = 1'b0;
         end
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         led_red <= 1'b0;
         led_green <= 1'b0;
      end else begin
         led_red <= red_next;
         led_green <= green_next;
      end
   end
   // ************************************************
   // checks
   // ************************************************
   single_colour_a: assert property (@(posedge sys_clk) disable iff (rst)
      !(led_red && led_green)) else $error("both colours driven");
   steady_green_a: assert property (@(posedge sys_clk) disable iff (rst)
      (pat == msld_pkg::MSLD_GREEN) |=> led_green && !led_red)
      else $error("operational not steady green");
   steady_red_a: assert property (@(posedge sys_clk) disable iff (rst)
      (pat == msld_pkg::MSLD_RED) |=> led_red && !led_green)
      else $error("unrecoverable fault not steady red");
   flash_green_a: assert property (@(posedge sys_clk) disable iff (rst)
      (pat == msld_pkg::MSLD_FLASH_GREEN) |=> !led_red && (led_green == $past(phase_reg)))
      else $error("standby not flashing green");
   flash_red_a: assert property (@(posedge sys_clk) disable iff (rst)
      (pat == msld_pkg::MSLD_FLASH_RED) |=> !led_green && (led_red == $past(phase_reg)))
      else $error("recoverable fault not flashing red");
   phase_toggle_a: assert property (@(posedge sys_clk) disable iff (rst)
      flash_if.expired |=> phase_reg != $past(phase_reg))
      else $error("flash phase did not toggle");
   test_first_a: assert property (@(posedge sys_clk) disable iff (rst)
      test_start |=> (st_reg == msld_pkg::MSLD_ST_GREEN1) ##1 led_green)
      else $error("self-test does not open green");
   test_order_a: assert property (@(posedge sys_clk) disable iff (rst)
      (selftest_active && !test_red) |=> led_green && !led_red)
      else $error("self-test not first in priority");
   net_after_a: assert property (@(posedge sys_clk) disable iff (rst)
      net_test_enable |-> (test_start || (st_reg != msld_pkg::MSLD_ST_DONE)))
      else $error("network test ahead of module test");
   test_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (st_reg == msld_pkg::MSLD_ST_GREEN2 && !selftest_active) |=>
      (st_reg == msld_pkg::MSLD_ST_DONE)) else $error("test not left on completion");
endmodule
`default_nettype wire

// ---- hw/msld_pkg.sv ----
/*
 * constants for the module status indicator driver.
 * assumes a 25 MHz system clock.
 */
package msld_pkg;
   // ************************************************
   // timing
   // ************************************************
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned TEST_PHASE_MS = 250;
   localparam int unsigned TEST_PHASE_CYC = (CLK_HZ / 1000) * TEST_PHASE_MS;
   localparam int unsigned FLASH_HALF_MS = 500;
   localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
   localparam int unsigned CNT_W = 24;
   // ************************************************
   // display patterns
   // ************************************************
   typedef enum logic [5:0] {
      MSLD_OFF = 6'h01,
      MSLD_GREEN = 6'h02,
      MSLD_FLASH_GREEN = 6'h04,
      MSLD_FLASH_RED = 6'h08,
      MSLD_RED = 6'h10,
      MSLD_TEST = 6'h20
   } msld_pattern_type;
   // ************************************************
   // self-test sequence states
   // ************************************************
   typedef enum logic [3:0] {
      MSLD_ST_GREEN1 = 4'h1,
      MSLD_ST_RED = 4'h2,
      MSLD_ST_GREEN2 = 4'h4,
      MSLD_ST_DONE = 4'h8
   } msld_test_state_type;
endpackage

// ---- hw/msld_if.sv ----
/*
 * carrier between the driver and its period timer.
 * assumes one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
interface msld_if;
   logic restart;
   logic expired;
   modport ctrl (output restart, input expired);
   modport timer (input restart, output expired);
endinterface
`default_nettype wire

// ---- hw/msld_timer.sv ----
/*
 * reloadable period timer: pulses expired every PERIOD cycles.
 * assumes restart is a one-cycle pulse from the controller.
 */
`timescale 1ns/1ns
`default_nettype none
module msld_timer #(
   parameter int unsigned PERIOD = msld_pkg::FLASH_HALF_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   msld_if.timer tif
);
   localparam logic [msld_pkg::CNT_W-1:0] LAST = msld_pkg::CNT_W'(PERIOD - 1);
   logic [msld_pkg::CNT_W-1:0] cnt_reg;
   logic [msld_pkg::CNT_W-1:0] cnt_next;
   assign tif.expired = (cnt_reg == LAST);
   assign cnt_next = (tif.restart || tif.expired) ? '0 : cnt_reg + 1'b1;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   period_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
      cnt_reg <= LAST) else $error("timer count beyond period");
endmodule
`default_nettype wire

// ---- tb/msld_led_model.sv ----
/*
 * bi-colour red/green indicator seen from the pins.
 * assumes active-high drives, sampled on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module msld_led_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // drives
   input wire logic led_red,
   input wire logic led_green,
   // view
   output logic [1:0] colour,
   output logic clash
);
   // one element: red, green or dark, never both
   assign colour = {led_red, led_green};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clash <= 1'b0;
      end else if (led_red === 1'b1 && led_green === 1'b1) begin
         clash <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_module_status_led_driver.sv ----
/*
 * self-checking bench for the indicator driver, short test and flash counts.
 * assumes the design files and the led model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module test_module_status_led_driver;
   localparam int TC = 8;
   localparam int FC = 4;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   // selftest, unrecoverable, recoverable, standby, operational
   logic [4:0] stat = 5'h00;
   logic net_test_enable;
   logic led_red;
   logic led_green;
   logic clash;
   logic [1:0] colour;
   int err_total = 0;
   int compares = 0;
   int n;
   int g;
   int r;
   msld_top #(.TEST_CYC(TC), .FLASH_CYC(FC)) dut (.sys_clk(sys_clk), .rst(rst),
      .selftest_active(stat[4]), .fault_unrecoverable(stat[3]),
      .fault_recoverable(stat[2]), .stat_standby(stat[1]), .stat_operational(stat[0]),
      .net_test_enable(net_test_enable), .led_red(led_red), .led_green(led_green));
   msld_led_model led (.sys_clk(sys_clk), .rst(rst), .led_red(led_red),
      .led_green(led_green), .colour(colour), .clash(clash));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // ************************************************
   // tasks
   // ************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic apply(input logic [4:0] v);
      @(posedge sys_clk);
      stat <= v;
   endtask
   task automatic wait_col(input logic [1:0] c);
      int k;
      k = 0;
      while (colour !== c && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      chk("colour reached", c, colour);
      if (k == 40) begin
         report_and_stop();
      end
   endtask
   task automatic run_len(input logic [1:0] c, output int len);
      len = 0;
      while (colour === c && len < 100) begin
         @(negedge sys_clk);
         len++;
      end
   endtask
   task automatic pattern(input string what, input logic [4:0] v, input int eg, input int er);
      apply(v);
      repeat (3) @(negedge sys_clk);
      g = 0;
      r = 0;
      // a window of whole flash periods
      repeat (4 * FC) begin
         @(negedge sys_clk);
         g += int'(led_green === 1'b1);
         r += int'(led_red === 1'b1);
      end
      chk({what, " green cycles"}, eg, g);
      chk({what, " red cycles"}, er, r);
      $display("test %s done", what);
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ************************************************
   // sequence
   // ************************************************
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk("leds after reset", 0, colour);
      $display("test reset done");
      apply(5'h18);
      @(negedge sys_clk);
      wait_col(2'b01);
      chk("net test enable", 1, net_test_enable);
      run_len(2'b01, n);
      chk("first green length", 1, n >= TC && n <= TC + 1);
      run_len(2'b10, n);
      chk("red length", 1, n >= TC && n <= TC + 1);
      run_len(2'b01, n);
      chk("final green held", 100, n);
      apply(5'h08);
      repeat (3) @(negedge sys_clk);
      chk("net test released", 0, net_test_enable);
      $display("test self-test done");
      pattern("unrecoverable", 5'h0f, 0, 4 * FC);
      pattern("operational", 5'h01, 4 * FC, 0);
      pattern("standby", 5'h03, 2 * FC, 0);
      pattern("recoverable", 5'h07, 0, 2 * FC);
      pattern("none", 5'h00, 0, 0);
      chk("both lit", 0, clash);
      // second reset in mid-run, operational status held throughout
      apply(5'h01);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk("leds after second reset", 0, colour);
      wait_col(2'b01);
      repeat (4) @(negedge sys_clk);
      chk("green after second reset", 2'b01, colour);
      chk("both lit after second reset", 0, clash);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
